// [ext_ctrl_defs.svh]
// Offsets, field positions, masks, reset values and seed of the extended control block
`ifndef EXT_CTRL_DEFS_SVH
`define EXT_CTRL_DEFS_SVH
`define EXT_CTRL_ADDR 5'h10
`define EXT_OVR_BIT 15
`define EXT_RSV_HI_MSB 14
`define EXT_RSV_HI_LSB 11
`define EXT_PADDR_MSB 10
`define EXT_PADDR_LSB 6
`define EXT_SCR_TEST_BIT 5
`define EXT_RSV4_BIT 4
`define EXT_NRZI_BIT 3
`define EXT_INVCODE_BIT 2
`define EXT_RSV1_BIT 1
`define EXT_SCR_DIS_BIT 0
`define EXT_RW_MASK 16'h802d
`define EXT_RESET_VALUE 16'h0008
`define EXT_PROT_MASK 16'h0000
`define EXT_LFSR_SEED 11'h7ff
`define EXT_FIFO_DEPTH 8
`endif

// [ext_ctrl_pkg.sv]
// Types shared by the extended control block
package ext_ctrl_pkg;
   // One transmit nibble from the MAC side
   typedef struct packed {
      logic tx_er;
      logic [3:0] nibble;
   } tx_nib_t;
   // One management write
   typedef struct packed {
      logic [4:0] reg_addr;
      logic [15:0] data;
   } mgmt_wr_t;
   // Line-stage state
   typedef enum logic [1:0] {
      LN_IDLE = 2'b00,
      LN_RUN = 2'b01
   } line_state_t;
endpackage

// [nib_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module nib_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage array
   logic [AW-1:0] wr_ptr_r; // Write pointer
   logic [AW-1:0] rd_ptr_r; // Read pointer
   logic [AW:0] count_r; // Occupancy
   logic push;
   logic pop;

   // Full and empty straight from occupancy
   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr_r];

   // Storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Pointers wrap at the depth
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // Occupancy count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
      end
   end
endmodule // nib_fifo

// [phy_extended_control.sv]
// Extended control register and the 100M transmit test path it steers
`timescale 1ns/10ps
`include "ext_ctrl_defs.svh"
// Overview of operation
// - Override bit lets next write change protected bits
// - Override bit self-clears after next write, unless that write to this register sets it again
// - Reserved bits 14:11, 4, 1 read zero
// - Port address caught from pins at reset
// - Soft reset keeps latched port address
// - Scrambler test mode forces lock loss
// - Line coding bit picks NRZ or NRZI at 100 Mb/s; always NRZ otherwise
// - Invalid code bit clear: standard 4B/5B only
// - Forced nibbles 0-7 map to leading-zero codes
// - Forced 8-b map 00000,01101,01100,10001
// - Forced c-f map 10000,11001,11000,11111
// - Scrambler disable bypasses scrambler and descrambler
// - Scrambling only in 100 Mb/s mode
module phy_extended_control #(
   parameter int FIFO_DEPTH = `EXT_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic soft_reset,
   input wire logic wr_en,
   input wire ext_ctrl_pkg::mgmt_wr_t wr,
   input wire logic [4:0] rd_addr,
   output logic [15:0] rd_data,
   input wire logic [15:0] prot_mask,
   output logic override_active,
   input wire logic port_addr4_pin,
   input wire logic port_addr3_pin,
   input wire logic port_addr2_pin,
   input wire logic port_addr1_pin,
   input wire logic port_addr0_pin,
   output logic [4:0] port_addr,
   input wire logic speed_100,
   input wire ext_ctrl_pkg::tx_nib_t tx_in,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   output logic tx_bit,
   input wire logic rx_bit,
   output logic rx_bit_out,
   output logic scr_lock_lost
);
   logic [15:0] ctrl_r; // Writable control bits
   logic [4:0] paddr_r; // Latched port address
   logic [4:0] pin_s1_r; // Pin synchroniser stage one
   logic [4:0] pin_s2_r; // Pin synchroniser stage two
   logic paddr_cap_r; // Capture still pending after reset release
   logic write_here;
   logic [15:0] wr_mask;
   logic [15:0] eff_mask;
   logic [4:0] code5;
   logic [4:0] fifo_data;
   logic fifo_valid;
   logic sh_ready;
   logic [4:0] shift_r; // Symbol shift register
   logic [2:0] bit_cnt_r; // Bits left in current symbol
   ext_ctrl_pkg::line_state_t ln_state_r; // Line stage state
   logic [10:0] tx_lfsr_r; // Transmit scrambler
   logic [10:0] rx_lfsr_r; // Receive descrambler
   logic nrz_prev_r; // Last NRZI line level
   logic scr_on;
   logic serial_bit;
   logic scr_bit;
   logic tx_bit_r;
   logic rx_out_r;

   assign write_here = wr_en && (wr.reg_addr == `EXT_CTRL_ADDR);

   // prot_mask is gated by EXT_PROT_MASK (zero), so every writable bit changes without override
   assign eff_mask = `EXT_RW_MASK & ~(prot_mask & `EXT_PROT_MASK);
   assign wr_mask = ctrl_r[`EXT_OVR_BIT] ? `EXT_RW_MASK : eff_mask;

   // Control register, soft reset returns defaults
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `EXT_RESET_VALUE;
      end else if (soft_reset) begin
         ctrl_r <= `EXT_RESET_VALUE;
      end else if (write_here) begin
         // Reserved positions never stored
         ctrl_r <= (wr.data & wr_mask) | (ctrl_r & ~wr_mask);
      end else if (wr_en) begin
         // Any other register write consumes the override
         ctrl_r[`EXT_OVR_BIT] <= 1'b0;
      end
   end

   assign override_active = ctrl_r[`EXT_OVR_BIT];

   // Pins pass two flops first; no reset, so the pin level is already settled at release
   always_ff @(posedge clk) begin
      pin_s1_r <= {port_addr4_pin, port_addr3_pin, port_addr2_pin,
                   port_addr1_pin, port_addr0_pin};
      pin_s2_r <= pin_s1_r;
   end

   // Capture the address once the synchroniser has settled after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         paddr_r <= 5'h00;
         paddr_cap_r <= 1'b1;
      end else if (paddr_cap_r) begin
         paddr_r <= pin_s2_r;
         paddr_cap_r <= 1'b0;
      end
      // Soft reset deliberately absent here
   end

   assign port_addr = paddr_r;

   // Readback: reserved bits zero, address from latch
   always_comb begin
      rd_data = 16'h0000;
      if (rd_addr == `EXT_CTRL_ADDR) begin
         rd_data = ctrl_r & `EXT_RW_MASK;
         rd_data[`EXT_PADDR_MSB:`EXT_PADDR_LSB] = paddr_r;
      end
   end

   // 4B/5B encoder with forced invalid-code table
   always_comb begin
      code5 = 5'h00;
      if (ctrl_r[`EXT_INVCODE_BIT] && tx_in.tx_er) begin
         case (tx_in.nibble)
            4'h8: code5 = 5'h00;
            4'h9: code5 = 5'h0d;
            4'ha: code5 = 5'h0c;
            4'hb: code5 = 5'h11;
            4'hc: code5 = 5'h10;
            4'hd: code5 = 5'h19;
            4'he: code5 = 5'h18;
            4'hf: code5 = 5'h1f;
            default: code5 = {1'b0, tx_in.nibble};
         endcase
      end else begin
         case (tx_in.nibble)
            4'h0: code5 = 5'h1e;
            4'h1: code5 = 5'h09;
            4'h2: code5 = 5'h14;
            4'h3: code5 = 5'h15;
            4'h4: code5 = 5'h0a;
            4'h5: code5 = 5'h0b;
            4'h6: code5 = 5'h0e;
            4'h7: code5 = 5'h0f;
            4'h8: code5 = 5'h12;
            4'h9: code5 = 5'h13;
            4'ha: code5 = 5'h16;
            4'hb: code5 = 5'h17;
            4'hc: code5 = 5'h1a;
            4'hd: code5 = 5'h1b;
            4'he: code5 = 5'h1c;
            default: code5 = 5'h1d;
         endcase
      end
   end

   // Symbol FIFO between encoder and serialiser
   nib_fifo #(
      .WIDTH(5),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_data(code5),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(sh_ready)
   );

   // Serialiser takes a symbol when its last bit is out
   assign sh_ready = (ln_state_r == ext_ctrl_pkg::LN_IDLE) || (bit_cnt_r == 3'd1);

   // Shift symbols MSB first; idle sends ones
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 5'h1f;
         bit_cnt_r <= 3'd0;
         ln_state_r <= ext_ctrl_pkg::LN_IDLE;
      end else begin
         case (ln_state_r)
            ext_ctrl_pkg::LN_IDLE: begin
               shift_r <= 5'h1f;
               if (fifo_valid) begin
                  shift_r <= fifo_data;
                  bit_cnt_r <= 3'd5;
                  ln_state_r <= ext_ctrl_pkg::LN_RUN;
               end
            end
            ext_ctrl_pkg::LN_RUN: begin
               if (bit_cnt_r == 3'd1) begin
                  if (fifo_valid) begin
                     shift_r <= fifo_data;
                     bit_cnt_r <= 3'd5;
                  end else begin
                     shift_r <= 5'h1f;
                     bit_cnt_r <= 3'd0;
                     ln_state_r <= ext_ctrl_pkg::LN_IDLE;
                  end
               end else begin
                  shift_r <= {shift_r[3:0], 1'b1};
                  bit_cnt_r <= bit_cnt_r - 3'd1;
               end
            end
            default: begin
               ln_state_r <= ext_ctrl_pkg::LN_IDLE;
            end
         endcase
      end
   end

   assign serial_bit = shift_r[4];

   // Scrambling only at 100M and when not disabled
   assign scr_on = speed_100 && !ctrl_r[`EXT_SCR_DIS_BIT];
   assign scr_bit = scr_on ? (serial_bit ^ tx_lfsr_r[10]) : serial_bit;

   // Transmit scrambler keystream
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_lfsr_r <= `EXT_LFSR_SEED;
      end else begin
         tx_lfsr_r <= {tx_lfsr_r[9:0], tx_lfsr_r[10] ^ tx_lfsr_r[8]};
      end
   end

   // Line coding: NRZ passes through, NRZI toggles on one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nrz_prev_r <= 1'b0;
         tx_bit_r <= 1'b0;
      end else if (ctrl_r[`EXT_NRZI_BIT] && speed_100) begin
         nrz_prev_r <= nrz_prev_r ^ scr_bit;
         tx_bit_r <= nrz_prev_r ^ scr_bit;
      end else begin
         nrz_prev_r <= scr_bit;
         tx_bit_r <= scr_bit;
      end
   end

   assign tx_bit = tx_bit_r;

   // Descrambler; test mode knocks it out of lock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_lfsr_r <= `EXT_LFSR_SEED;
         rx_out_r <= 1'b0;
         scr_lock_lost <= 1'b0;
      end else begin
         scr_lock_lost <= ctrl_r[`EXT_SCR_TEST_BIT];
         if (ctrl_r[`EXT_SCR_TEST_BIT]) begin
            rx_lfsr_r <= `EXT_LFSR_SEED;
         end else begin
            rx_lfsr_r <= {rx_lfsr_r[9:0], rx_lfsr_r[10] ^ rx_lfsr_r[8]};
         end
         rx_out_r <= scr_on ? (rx_bit ^ rx_lfsr_r[10]) : rx_bit;
      end
   end

   assign rx_bit_out = rx_out_r;
endmodule // phy_extended_control

// [ext_ctrl_chk_props.sv]
// Port-level assertions for the extended control block
`timescale 1ns/10ps
module ext_ctrl_chk #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic soft_reset,
   input wire logic wr_en,
   input wire ext_ctrl_pkg::mgmt_wr_t wr,
   input wire logic [4:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic override_active,
   input wire logic [4:0] port_addr,
   input wire logic scr_lock_lost
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // A write that lands on this register
   sequence s_wr_ctrl;
      wr_en && wr.reg_addr == 5'h10 && !soft_reset;
   endsequence
   property p_rsv_zero;
      rd_addr == 5'h10 |-> rd_data[14:11] == 4'h0 && !rd_data[4] && !rd_data[1];
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bits read nonzero");
   property p_rd_other;
      rd_addr != 5'h10 |-> rd_data == 16'h0000;
   endproperty
   a_rd_other: assert property (p_rd_other)
      else $error("unmapped read nonzero");
   property p_paddr_read;
      rd_addr == 5'h10 |-> rd_data[10:6] == port_addr;
   endproperty
   a_paddr_read: assert property (p_paddr_read)
      else $error("address field differs from latched address");
   property p_ovr_set;
      s_wr_ctrl and wr.data[15] |=> override_active;
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("override not set");
   property p_ovr_clear;
      wr_en && override_active && !(wr.reg_addr == 5'h10 && wr.data[15]) |=> !override_active;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear)
      else $error("override did not self-clear");
   property p_ovr_hold;
      !wr_en && !soft_reset |=> $stable(override_active);
   endproperty
   a_ovr_hold: assert property (p_ovr_hold)
      else $error("override changed without a write");
   property p_paddr_keep;
      soft_reset && $past(rstn, 2) |=> $stable(port_addr);
   endproperty
   a_paddr_keep: assert property (p_paddr_keep)
      else $error("soft reset changed port address");
   property p_lock;
      s_wr_ctrl ##1 (!wr_en && !soft_reset) |=> scr_lock_lost == $past(wr.data[5], 2);
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock loss does not follow test bit");
endmodule // ext_ctrl_chk
bind phy_extended_control ext_ctrl_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .rstn,
   .soft_reset, .wr_en, .wr, .rd_addr, .rd_data, .override_active, .port_addr,
   .scr_lock_lost);

// [mac_src.sv]
// MAC-side nibble source for the transmit handshake
`timescale 1ns/10ps
module mac_src (
   input wire logic clk,
   input wire logic tx_in_ready,
   output ext_ctrl_pkg::tx_nib_t tx_in,
   output logic tx_in_valid
);
   initial begin
      tx_in = '0;
      tx_in_valid = 1'b0;
   end
   // Offers one nibble after gap plus one cycles and holds it until taken
   task send(input logic [3:0] n, input logic e, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      #1;
      tx_in = '{e, n};
      tx_in_valid = 1'b1;
      while (tx_in_ready !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
      tx_in_valid = 1'b0;
      // Released lines show no stale value
      tx_in = ~tx_in;
   endtask
endmodule // mac_src

// [tb.sv]
// Self-checking bench for the extended control block
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic clk, rstn, soft_reset, wr_en, speed_100, rx_bit, tx_bit, rx_bit_out, p;
   logic override_active, tx_in_valid, tx_in_ready, scr_lock_lost;
   logic [4:0] pins, port_addr, rd_addr, got;
   logic [15:0] rd_data, prot_mask;
   int errors, cmp_count, cycles, i;
   ext_ctrl_pkg::mgmt_wr_t wr;
   ext_ctrl_pkg::tx_nib_t tx_in;
   mac_src mac (.clk, .tx_in_ready, .tx_in, .tx_in_valid);
   phy_extended_control #(.FIFO_DEPTH(8)) DUT (.clk, .rstn, .soft_reset, .wr_en, .wr,
      .rd_addr, .rd_data, .prot_mask, .override_active, .port_addr4_pin(pins[4]),
      .port_addr3_pin(pins[3]), .port_addr2_pin(pins[2]), .port_addr1_pin(pins[1]),
      .port_addr0_pin(pins[0]), .port_addr, .speed_100, .tx_in, .tx_in_valid,
      .tx_in_ready, .tx_bit, .rx_bit, .rx_bit_out, .scr_lock_lost);
   always #50 clk = ~clk;
   // Cuts a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end
   task results;
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   // Management write, reserved bits zero unless a refusal is meant
   task wr_reg(input logic [4:0] a, input logic [15:0] d);
      step();
      wr_en = 1;
      wr = '{a, d};
      step();
      wr_en = 0;
   endtask
   task rd_chk(input logic [4:0] a, input logic [15:0] e);
      rd_addr = a;
      #1;
      `CHK(rd_data, e)
   endtask
   // Sends a nibble and frames the serial bits from the first zero
   task tx_chk(input logic [3:0] n, input logic er, input logic [4:0] e);
      int k;
      repeat (8) step();
      mac.send(n, er, 2);
      k = 0;
      while (tx_bit !== 1'b0 && k < 60) begin
         step();
         k++;
      end
      got[4] = tx_bit;
      for (k = 3; k >= 0; k--) begin
         step();
         got[k] = tx_bit;
      end
      `CHK(got, e)
   endtask
   task rx_chk;
      for (i = 0; i < 6; i++) begin
         rx_bit = i[0] ^ i[1];
         step();
         `CHK(rx_bit_out, i[0] ^ i[1])
      end
   endtask
   // Idle line: steady ones, or toggling under NRZI
   task idle_chk(input logic t);
      for (i = 0; i < 4; i++) begin
         p = tx_bit;
         step();
         `CHK(tx_bit, t ? ~p : 1'b1)
      end
   endtask
   task rdy_wait(input logic v);
      int k;
      k = 0;
      while (tx_in_ready !== v && k < 200) begin
         step();
         k++;
      end
      `CHK(tx_in_ready, v)
   endtask
   initial begin
      clk = 0;
      rstn = 0;
      soft_reset = 0;
      wr_en = 0;
      wr = '0;
      rd_addr = 5'h00;
      prot_mask = 16'h0000;
      pins = 5'h15;
      speed_100 = 1;
      rx_bit = 0;
      errors = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      #1 rstn = 1;
      step();
      `CHK(port_addr, 5'h15)
      rd_chk(5'h10, 16'h0548);
      pins = 5'h0a;
      wr_reg(5'h10, 16'hffff);
      rd_chk(5'h10, 16'h856d);
      `CHK(override_active, 1'b1)
      wr_reg(5'h00, 16'h0000);
      `CHK(override_active, 1'b0)
      rd_chk(5'h00, 16'h0000);
      `CHK(scr_lock_lost, 1'b1)
      step();
      soft_reset = 1;
      step();
      soft_reset = 0;
      step();
      rd_chk(5'h10, 16'h0548);
      `CHK(scr_lock_lost, 1'b0)
      wr_reg(5'h10, 16'h8000);
      wr_reg(5'h10, 16'h0005);
      `CHK(override_active, 1'b0)
      rx_chk();
      idle_chk(1'b0);
      for (i = 0; i < 8; i++) tx_chk(i[3:0], 1'b1, i[4:0]);
      tx_chk(4'h8, 1'b1, 5'h00);
      tx_chk(4'h9, 1'b1, 5'h0d);
      tx_chk(4'ha, 1'b1, 5'h0c);
      tx_chk(4'hb, 1'b1, 5'h03);
      tx_chk(4'hc, 1'b1, 5'h01);
      tx_chk(4'hd, 1'b1, 5'h07);
      tx_chk(4'he, 1'b1, 5'h03);
      tx_chk(4'h0, 1'b0, 5'h0f);
      wr_reg(5'h10, 16'h000d);
      idle_chk(1'b1);
      speed_100 = 0;
      wr_reg(5'h10, 16'h0008);
      repeat (4) step();
      idle_chk(1'b0);
      rx_chk();
      speed_100 = 1;
      wr_reg(5'h10, 16'h0005);
      // Burst overfills the buffer while the serialiser drains it
      fork
         for (int j = 0; j < 16; j++) mac.send(j[3:0], 1'b0, 0);
      join_none
      rdy_wait(1'b0);
      repeat (100) step();
      rdy_wait(1'b1);
      results();
   end
endmodule // tb
